// ==== verilog/eel_phy_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eel_defines.svh"
module eel_phy_dev #(
    parameter int QUIET_CYC   = `EEL_QUIET_CYC,
    parameter int REFRESH_CYC = `EEL_REFRESH_CYC,
    parameter int NLP_CYC     = `EEL_NLP_CYC
) (
    // system
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // mii and management
    eel_mii_if.phy           mii,
    // line receive
    input  wire logic        line_rx_sleep,
    input  wire logic        line_rx_dv,
    input  wire logic [3:0]  line_rx_nibble,
    input  wire logic        line_link_100,
    input  wire logic [15:0] line_partner_adv,
    // line transmit
    output logic             line_tx_en,
    output logic [3:0]       line_tx_nibble,
    output logic             line_refresh,
    output logic             line_nlp,
    output logic             line_swing_low,
    // status
    output logic             an_restart,
    output logic             eee_enabled,
    output logic             tx_lpi,
    output logic             rx_lpi
);
    // input synchronisers
    logic [29:0] in_raw;
    logic [29:0] sync1_r;
    logic [29:0] sync2_r;
    assign in_raw = {line_partner_adv, line_link_100, line_rx_sleep, line_rx_dv, line_rx_nibble,
                     mii.mgmt_req, mii.txen, mii.txer, mii.txd};
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sync1_r <= 30'h0;
            sync2_r <= 30'h0;
        end
        else if (ce)
        begin
            sync1_r <= in_raw;
            sync2_r <= sync1_r;
        end

    wire [3:0]  txd_s     = sync2_r[3:0];
    wire        txer_s    = sync2_r[4];
    wire        txen_s    = sync2_r[5];
    wire        req_s     = sync2_r[6];
    wire [3:0]  rxnib_s   = sync2_r[10:7];
    wire        rxdv_s    = sync2_r[11];
    wire        sleep_s   = sync2_r[12];
    wire        link100_s = sync2_r[13];
    wire [15:0] partner_s = sync2_r[29:14];

    // mii clock divider
    logic [2:0] div_r;
    logic       clk_r;
    logic       rxc_r;
    wire        half_done = (div_r == 3'(`EEL_MII_HALF - 1));
    wire        fall_tick = ce & half_done & clk_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            div_r <= 3'h0;
            clk_r <= 1'b0;
        end
        else if (ce)
        begin
            div_r <= half_done ? 3'h0 : div_r + 3'h1;
            if (half_done)
                clk_r <= ~clk_r;
        end
    assign mii.txc = clk_r;

    // management registers
    logic [15:0] std_ctrl_r, afe4_r, pma_ctrl_r, pcs_ctrl_r, adv_r, vend4_r;
    logic [15:0] rdata_r;
    logic        ack_r, an_restart_r, eee_en_r;
    wire [4:0]   m_dev  = mii.mgmt_dev;
    wire [5:0]   m_reg  = mii.mgmt_reg;
    wire         m_take = req_s & ~ack_r;
    wire         m_wr   = m_take & mii.mgmt_we;
    wire         hit_std  = (m_dev == `EEL_DEV_STD)  && (m_reg == `EEL_REG_STD_CTRL);
    wire         hit_afe  = (m_dev == `EEL_DEV_STD)  && (m_reg == `EEL_REG_AFE4);
    wire         hit_pmac = (m_dev == `EEL_DEV_PMA)  && (m_reg == `EEL_REG_PMA_CTRL);
    wire         hit_pmas = (m_dev == `EEL_DEV_PMA)  && (m_reg == `EEL_REG_PMA_STAT);
    wire         hit_pcs  = (m_dev == `EEL_DEV_PCS)  && (m_reg == `EEL_REG_PCS_CTRL);
    wire         hit_adv  = (m_dev == `EEL_DEV_AN)   && (m_reg == `EEL_REG_ADV);
    wire         hit_part = (m_dev == `EEL_DEV_AN)   && (m_reg == `EEL_REG_PARTNER);
    wire         hit_vend = (m_dev == `EEL_DEV_VEND) && (m_reg == `EEL_REG_VEND4);
    logic [15:0] pma_stat_w;
    logic        rx_lpi_r, tx_lpi_r;
    always_comb
    begin
        pma_stat_w = 16'h0;
        pma_stat_w[`EEL_BIT_RX_LPI] = rx_lpi_r;
        pma_stat_w[`EEL_BIT_TX_LPI] = tx_lpi_r;
    end
    wire [15:0]  rd_mux = hit_std  ? std_ctrl_r :
                          hit_afe  ? afe4_r :
                          hit_pmac ? pma_ctrl_r :
                          hit_pmas ? pma_stat_w :
                          hit_pcs  ? pcs_ctrl_r :
                          hit_adv  ? adv_r :
                          hit_part ? partner_s :
                          hit_vend ? vend4_r : 16'h0;
    wire         restart_w = m_wr & hit_std & mii.mgmt_wdata[`EEL_BIT_AN_RESTART];
    wire         clk_stop_en = pcs_ctrl_r[`EEL_BIT_CLK_STOP];

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            std_ctrl_r   <= 16'h0;
            afe4_r       <= 16'h0;
            pma_ctrl_r   <= 16'h0;
            pcs_ctrl_r   <= `EEL_PCS_CTRL_RST;
            adv_r        <= 16'h0;
            vend4_r      <= `EEL_VEND4_RST;
            rdata_r      <= 16'h0;
            ack_r        <= 1'b0;
            an_restart_r <= 1'b0;
            eee_en_r     <= 1'b0;
        end
        else if (ce)
        begin
            an_restart_r <= restart_w;
            if (an_restart_r)
                eee_en_r <= adv_r[`EEL_BIT_ADV_100] & partner_s[`EEL_BIT_ADV_100];
            if (m_take)
            begin
                ack_r   <= 1'b1;
                rdata_r <= rd_mux;
            end
            else if (!req_s)
                ack_r <= 1'b0;
            if (m_wr)
            begin
                if (hit_std)
                    std_ctrl_r <= mii.mgmt_wdata & ~(16'h1 << `EEL_BIT_AN_RESTART);
                if (hit_afe)
                    afe4_r <= mii.mgmt_wdata;
                if (hit_pmac)
                    pma_ctrl_r <= mii.mgmt_wdata;
                if (hit_pcs)
                    pcs_ctrl_r <= mii.mgmt_wdata;
                if (hit_adv)
                    adv_r <= mii.mgmt_wdata;
                if (hit_vend)
                    vend4_r <= mii.mgmt_wdata;
            end
        end
    assign mii.mgmt_ack   = ack_r;
    assign mii.mgmt_rdata = rdata_r;

    // receive low-power idle, paced by the mii clock
    eel_pkg::eel_rx_state_t rx_state_r;
    logic [3:0] rx_cnt_r;
    logic       rxdv_r, rxer_r;
    logic [3:0] rxd_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            rx_state_r <= eel_pkg::EEL_RX_NORM;
            rx_cnt_r   <= 4'h0;
            rxdv_r     <= 1'b0;
            rxer_r     <= 1'b0;
            rxd_r      <= 4'h0;
        end
        else if (fall_tick)
        begin
            case (rx_state_r)
                eel_pkg::EEL_RX_NORM:
                    if (sleep_s)
                    begin
                        rx_state_r <= eel_pkg::EEL_RX_LPI;
                        rx_cnt_r   <= 4'h0;
                        rxdv_r     <= 1'b0;
                        rxer_r     <= 1'b1;
                        rxd_r      <= `EEL_LPI_NIBBLE;
                    end
                    else
                    begin
                        rxdv_r <= rxdv_s;
                        rxer_r <= 1'b0;
                        rxd_r  <= rxnib_s;
                    end
                eel_pkg::EEL_RX_LPI:
                    if (!sleep_s)
                    begin
                        rx_state_r <= eel_pkg::EEL_RX_NORM;
                        rxdv_r     <= rxdv_s;
                        rxer_r     <= 1'b0;
                        rxd_r      <= rxnib_s;
                    end
                    else if (rx_cnt_r != 4'(`EEL_RXC_STOP_PERIODS - 1))
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                    else if (clk_stop_en)
                        rx_state_r <= eel_pkg::EEL_RX_STOP;
                eel_pkg::EEL_RX_STOP:
                    if (!sleep_s)
                        rx_state_r <= eel_pkg::EEL_RX_WAKE;
                    else if (!clk_stop_en)
                        rx_state_r <= eel_pkg::EEL_RX_LPI;
                eel_pkg::EEL_RX_WAKE:
                begin
                    rx_state_r <= eel_pkg::EEL_RX_NORM;
                    rxdv_r     <= rxdv_s;
                    rxer_r     <= 1'b0;
                    rxd_r      <= rxnib_s;
                end
                default:
                    rx_state_r <= eel_pkg::EEL_RX_NORM;
            endcase
        end

    // receive clock, held low while stopped
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            rxc_r <= 1'b0;
        else if (ce & half_done)
            rxc_r <= ~clk_r & (rx_state_r != eel_pkg::EEL_RX_STOP);
    assign mii.rxc  = rxc_r;
    assign mii.rxdv = rxdv_r;
    assign mii.rxer = rxer_r;
    assign mii.rxd  = rxd_r;

    // transmit low-power idle and refresh timing
    eel_pkg::eel_tx_state_t tx_state_r;
    logic [20:0] tmr_r, nlp_tmr_r;
    logic        tx_en_r, refresh_r, nlp_r;
    logic [3:0]  tx_nib_r;
    wire         lpi_pat = ~txen_s & txer_s & (txd_s == `EEL_LPI_NIBBLE);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            tx_state_r <= eel_pkg::EEL_TX_ACTIVE;
            tmr_r      <= 21'h0;
            tx_lpi_r   <= 1'b0;
            rx_lpi_r   <= 1'b0;
            tx_en_r    <= 1'b0;
            tx_nib_r   <= 4'h0;
            refresh_r  <= 1'b0;
        end
        else if (ce)
        begin
            tx_lpi_r <= lpi_pat;
            rx_lpi_r <= (rx_state_r != eel_pkg::EEL_RX_NORM);
            tx_en_r  <= txen_s & ~lpi_pat;
            tx_nib_r <= lpi_pat ? 4'h0 : txd_s;
            tmr_r    <= tmr_r + 21'h1;
            case (tx_state_r)
                eel_pkg::EEL_TX_ACTIVE:
                begin
                    tmr_r <= 21'h0;
                    if (lpi_pat)
                    begin
                        tx_state_r <= eel_pkg::EEL_TX_REFRESH;
                        refresh_r  <= 1'b1;
                    end
                end
                eel_pkg::EEL_TX_REFRESH:
                    if (!lpi_pat)
                    begin
                        tx_state_r <= eel_pkg::EEL_TX_ACTIVE;
                        refresh_r  <= 1'b0;
                    end
                    else if (tmr_r == 21'(REFRESH_CYC - 1))
                    begin
                        tx_state_r <= eel_pkg::EEL_TX_QUIET;
                        refresh_r  <= 1'b0;
                        tmr_r      <= 21'h0;
                    end
                eel_pkg::EEL_TX_QUIET:
                    if (!lpi_pat)
                        tx_state_r <= eel_pkg::EEL_TX_ACTIVE;
                    else if (tmr_r == 21'(QUIET_CYC - 1))
                    begin
                        tx_state_r <= eel_pkg::EEL_TX_REFRESH;
                        refresh_r  <= 1'b1;
                        tmr_r      <= 21'h0;
                    end
                default:
                    tx_state_r <= eel_pkg::EEL_TX_ACTIVE;
            endcase
        end

    // link pulses in plain 10 Mbps idle
    wire nlp_due = (nlp_tmr_r == 21'(NLP_CYC - 1));
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            nlp_tmr_r <= 21'h0;
            nlp_r     <= 1'b0;
        end
        else if (ce)
        begin
            nlp_r <= 1'b0;
            if (link100_s || tx_en_r)
                nlp_tmr_r <= 21'h0;
            else
            begin
                nlp_tmr_r <= nlp_due ? 21'h0 : nlp_tmr_r + 21'h1;
                nlp_r     <= nlp_due;
            end
        end

    assign line_tx_en     = tx_en_r;
    assign line_tx_nibble = tx_nib_r;
    assign line_refresh   = refresh_r;
    assign line_nlp       = nlp_r;
    assign line_swing_low = afe4_r[`EEL_BIT_AFE_TE] & ~vend4_r[`EEL_BIT_VEND_TE];
    assign an_restart     = an_restart_r;
    assign eee_enabled    = eee_en_r;
    assign tx_lpi         = tx_lpi_r;
    assign rx_lpi         = rx_lpi_r;
endmodule
`default_nettype wire

// ==== common/eel_defines.svh ====
`ifndef EEL_DEFINES_SVH
`define EEL_DEFINES_SVH

// timing
`define EEL_CLK_MHZ           50
`define EEL_MII_HALF          4
`define EEL_RXC_STOP_PERIODS  9
`define EEL_WAKE_US           30
`define EEL_REFRESH_US        200
`define EEL_REFRESH_PERIOD_US 20000
`define EEL_NLP_US            16000
`define EEL_REFRESH_CYC       (`EEL_REFRESH_US * `EEL_CLK_MHZ)
`define EEL_QUIET_CYC         ((`EEL_REFRESH_PERIOD_US - `EEL_REFRESH_US) * `EEL_CLK_MHZ)
`define EEL_NLP_CYC           (`EEL_NLP_US * `EEL_CLK_MHZ)
`define EEL_RXC_LOST_CYC      16

// management devices and registers
`define EEL_DEV_STD           5'h00
`define EEL_DEV_PMA           5'h01
`define EEL_DEV_PCS           5'h03
`define EEL_DEV_AN            5'h07
`define EEL_DEV_VEND          5'h1C
`define EEL_REG_STD_CTRL      6'h00
`define EEL_REG_AFE4          6'h13
`define EEL_REG_PMA_CTRL      6'h00
`define EEL_REG_PMA_STAT      6'h01
`define EEL_REG_PCS_CTRL      6'h00
`define EEL_REG_ADV           6'h3C
`define EEL_REG_PARTNER       6'h3D
`define EEL_REG_VEND4         6'h04

// fields and reset values
`define EEL_BIT_AN_RESTART    9
`define EEL_BIT_CLK_STOP      10
`define EEL_BIT_ADV_100       1
`define EEL_BIT_AFE_TE        4
`define EEL_BIT_VEND_TE       13
`define EEL_BIT_RX_LPI        8
`define EEL_BIT_TX_LPI        9
`define EEL_PCS_CTRL_RST      16'h0400
`define EEL_VEND4_RST         16'h2000
`define EEL_LPI_NIBBLE        4'h1

// host apb map
`define EEL_A_CTRL            8'h00
`define EEL_A_STATUS          8'h04
`define EEL_A_INT_STAT        8'h08
`define EEL_A_INT_MASK        8'h0C
`define EEL_A_MGMT_CMD        8'h10
`define EEL_A_MGMT_WDATA      8'h14
`define EEL_A_MGMT_RDATA      8'h18
`define EEL_INT_RX_ENTER      0
`define EEL_INT_RX_EXIT       1
`define EEL_INT_MGMT_DONE     2

`endif

// ==== common/eel_pkg.sv ====
package eel_pkg;
    typedef enum logic [1:0]
    {
        EEL_RX_NORM = 2'b00,
        EEL_RX_LPI  = 2'b01,
        EEL_RX_STOP = 2'b10,
        EEL_RX_WAKE = 2'b11
    } eel_rx_state_t;

    typedef enum logic [1:0]
    {
        EEL_TX_ACTIVE  = 2'b00,
        EEL_TX_REFRESH = 2'b01,
        EEL_TX_QUIET   = 2'b10
    } eel_tx_state_t;
endpackage

// ==== common/eel_mii_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface eel_mii_if;
    logic        txc;
    logic        txen;
    logic        txer;
    logic [3:0]  txd;
    logic        rxc;
    logic        rxdv;
    logic        rxer;
    logic [3:0]  rxd;
    logic        mgmt_req;
    logic        mgmt_we;
    logic [4:0]  mgmt_dev;
    logic [5:0]  mgmt_reg;
    logic [15:0] mgmt_wdata;
    logic [15:0] mgmt_rdata;
    logic        mgmt_ack;

    modport phy (output txc, rxc, rxdv, rxer, rxd, mgmt_rdata, mgmt_ack,
                 input txen, txer, txd, mgmt_req, mgmt_we, mgmt_dev, mgmt_reg, mgmt_wdata);
    modport mac (input txc, rxc, rxdv, rxer, rxd, mgmt_rdata, mgmt_ack,
                 output txen, txer, txd, mgmt_req, mgmt_we, mgmt_dev, mgmt_reg, mgmt_wdata);
endinterface
`default_nettype wire

// ==== verilog/eel_mac_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eel_defines.svh"
module eel_mac_host (
    // system
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // user data
    input  wire logic        tx_valid,
    input  wire logic [3:0]  tx_nibble,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [3:0]       rx_nibble,
    // mii and management
    eel_mii_if.mac           mii
);
    // synchronisers for phy-sourced signals
    logic [8:0] sync1_r, sync2_r, prev_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sync1_r <= 9'h0;
            sync2_r <= 9'h0;
            prev_r  <= 9'h0;
        end
        else if (ce)
        begin
            sync1_r <= {mii.mgmt_ack, mii.txc, mii.rxc, mii.rxdv, mii.rxer, mii.rxd};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    wire [3:0] rxd_s    = sync2_r[3:0];
    wire       rxer_s   = sync2_r[4];
    wire       rxdv_s   = sync2_r[5];
    wire       rxc_rise = ce & sync2_r[6] & ~prev_r[6];
    wire       txc_rise = ce & sync2_r[7] & ~prev_r[7];
    wire       ack_s    = sync2_r[8];

    // apb decode
    logic [31:0] ctrl_r, mask_r, wdata_r, rdata_r, prdata_r;
    logic [2:0]  stat_r;
    logic [16:0] cmd_r;
    logic        req_r, busy_r, irq_r, rx_lpi_r, rx_valid_r, txen_r, txer_r;
    logic [3:0]  rx_nib_r, txd_r;
    logic [4:0]  lost_r;
    wire         setup  = psel & ~penable;
    wire         wr     = psel & penable & pwrite;
    wire         a_ctrl = (paddr == `EEL_A_CTRL);
    wire         a_stat = (paddr == `EEL_A_STATUS);
    wire         a_int  = (paddr == `EEL_A_INT_STAT);
    wire         a_mask = (paddr == `EEL_A_INT_MASK);
    wire         a_cmd  = (paddr == `EEL_A_MGMT_CMD);
    wire         a_wd   = (paddr == `EEL_A_MGMT_WDATA);
    wire         a_rd   = (paddr == `EEL_A_MGMT_RDATA);
    wire         mapped = a_ctrl | a_stat | a_int | a_mask | a_cmd | a_wd | a_rd;
    wire         rxc_stopped = (lost_r == 5'(`EEL_RXC_LOST_CYC));
    wire [31:0]  status_w = {28'h0, busy_r, rxc_stopped, rx_lpi_r, txer_r & ~txen_r};
    wire [31:0]  rd_mux = a_ctrl ? ctrl_r :
                          a_stat ? status_w :
                          a_int  ? {29'h0, stat_r} :
                          a_mask ? mask_r :
                          a_cmd  ? {15'h0, cmd_r} :
                          a_wd   ? wdata_r :
                          a_rd   ? rdata_r : 32'h0;
    wire         start  = wr & a_cmd & ~busy_r;
    wire         done   = req_r & ack_s;
    wire         rx_pat = ~rxdv_s & rxer_s & (rxd_s == `EEL_LPI_NIBBLE);
    wire [2:0]   ev     = {done, rxc_rise & rx_lpi_r & ~rx_pat, rxc_rise & ~rx_lpi_r & rx_pat};
    wire [2:0]   w1c    = (wr & a_int) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ctrl_r   <= 32'h0;
            mask_r   <= 32'h0;
            wdata_r  <= 32'h0;
            rdata_r  <= 32'h0;
            prdata_r <= 32'h0;
            stat_r   <= 3'h0;
            cmd_r    <= 17'h0;
            req_r    <= 1'b0;
            busy_r   <= 1'b0;
            irq_r    <= 1'b0;
        end
        else if (ce)
        begin
            if (setup)
                prdata_r <= rd_mux;
            if (wr & a_ctrl)
                ctrl_r <= {31'h0, pwdata[0]};
            if (wr & a_mask)
                mask_r <= {29'h0, pwdata[2:0]};
            if (wr & a_wd)
                wdata_r <= {16'h0, pwdata[15:0]};
            stat_r <= (stat_r & ~w1c) | ev;
            irq_r  <= |(stat_r & mask_r[2:0]);
            if (start)
            begin
                cmd_r  <= pwdata[16:0];
                req_r  <= 1'b1;
                busy_r <= 1'b1;
            end
            else if (done)
            begin
                req_r   <= 1'b0;
                rdata_r <= {16'h0, mii.mgmt_rdata};
            end
            else if (!req_r && !ack_s)
                busy_r <= 1'b0;
        end
    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign irq     = irq_r;
    assign mii.mgmt_req   = req_r;
    assign mii.mgmt_we    = cmd_r[16];
    assign mii.mgmt_dev   = cmd_r[12:8];
    assign mii.mgmt_reg   = cmd_r[5:0];
    assign mii.mgmt_wdata = wdata_r[15:0];

    // transmit, one nibble per transmit clock
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            txen_r <= 1'b0;
            txer_r <= 1'b0;
            txd_r  <= 4'h0;
        end
        else if (txc_rise)
        begin
            if (tx_valid)
            begin
                txen_r <= 1'b1;
                txer_r <= 1'b0;
                txd_r  <= tx_nibble;
            end
            else if (ctrl_r[0])
            begin
                txen_r <= 1'b0;
                txer_r <= 1'b1;
                txd_r  <= `EEL_LPI_NIBBLE;
            end
            else
            begin
                txen_r <= 1'b0;
                txer_r <= 1'b0;
                txd_r  <= 4'h0;
            end
        end
    assign tx_ready = txc_rise;
    assign mii.txen = txen_r;
    assign mii.txer = txer_r;
    assign mii.txd  = txd_r;

    // receive and receive clock watchdog
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            rx_valid_r <= 1'b0;
            rx_nib_r   <= 4'h0;
            rx_lpi_r   <= 1'b0;
            lost_r     <= 5'h0;
        end
        else if (ce)
        begin
            rx_valid_r <= rxc_rise & rxdv_s;
            if (rxc_rise)
            begin
                rx_nib_r <= rxd_s;
                rx_lpi_r <= rx_pat;
                lost_r   <= 5'h0;
            end
            else if (!rxc_stopped)
                lost_r <= lost_r + 5'h1;
        end
    assign rx_valid  = rx_valid_r;
    assign rx_nibble = rx_nib_r;
endmodule
`default_nettype wire

// ==== verification/eel_lpi_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module eel_lpi_asserts (
    // clock, reset and watched lines
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       txc,
    input wire logic       rxc,
    input wire logic       rxdv,
    input wire logic       rxer,
    input wire logic [3:0] rxd,
    input wire logic       mgmt_req,
    input wire logic       mgmt_ack
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_txc_running: assert property (1'h1 |-> ##[1:8] $changed(txc)) else $error("txc stalled");
    chk_rx_idle_code: assert property (rxer && !rxdv |-> rxd == 4'h1) else $error("rx idle code");
    chk_rxc_stop_idle: assert property ($stable(rxc) [*8] |-> !rxc && rxer && !rxdv) else $error("rxc stop");
    chk_ack_has_req: assert property ($rose(mgmt_ack) |-> mgmt_req) else $error("ack alone");
    chk_ack_held: assert property (mgmt_ack && mgmt_req |=> mgmt_ack) else $error("ack early");
    chk_req_held: assert property (mgmt_req && !mgmt_ack |=> mgmt_req) else $error("req early");
    chk_ack_in_time: assert property ($rose(mgmt_req) |-> ##[1:6] mgmt_ack) else $error("ack late");
    chk_ack_released: assert property ($fell(mgmt_req) |-> ##[1:4] !mgmt_ack) else $error("ack stuck");
    cover property ($stable(rxc) [*8]);
    cover property ($rose(rxer));
    cover property ($rose(mgmt_ack));
endmodule
`default_nettype wire

// ==== verification/eee_lpi_mii_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CK(n,e,g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s %0h %0h", n, e, g); end end
module eee_lpi_mii_control_test;
    logic        pclk = 1'h0, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, sleep, err;
    logic        tx_lpi, rx_lpi, eee_en, rdv, tv, lk, refr, nlp, swing, an_rst, rxv, txr, ltxen;
    logic [3:0]  rnib, tn, rxn, ltxn;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] padv;
    int          n_mismatch = 0, n_tests = 0, k, n_an = 0;
    localparam logic [26:0] ROWS [3] = '{{5'h03, 6'h00, 16'h0400}, {5'h1C, 6'h04, 16'h2000}, {5'h07, 6'h3C, 16'h0}};
    eel_mii_if mii ();
    eel_phy_dev #(.QUIET_CYC(300), .REFRESH_CYC(50), .NLP_CYC(100)) i_eel_phy_dev (.pclk, .presetn, .ce, .mii(mii),
        .line_rx_sleep(sleep), .line_rx_dv(rdv), .line_rx_nibble(rnib), .line_link_100(lk), .line_partner_adv(padv),
        .line_tx_en(ltxen), .line_tx_nibble(ltxn), .line_refresh(refr), .line_nlp(nlp), .line_swing_low(swing),
        .an_restart(an_rst), .eee_enabled(eee_en), .tx_lpi, .rx_lpi);
    eel_mac_host i_eel_mac_host (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .irq, .tx_valid(tv), .tx_nibble(tn), .tx_ready(txr), .rx_valid(rxv), .rx_nibble(rxn), .mii(mii));
    eel_lpi_asserts i_eel_lpi_asserts (.pclk, .presetn, .txc(mii.txc), .rxc(mii.rxc), .rxdv(mii.rxdv),
        .rxer(mii.rxer), .rxd(mii.rxd), .mgmt_req(mii.mgmt_req), .mgmt_ack(mii.mgmt_ack));
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) n_an += an_rst;
    task automatic end_sim(input bit hung);
        n_mismatch += hung;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++k < 20);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        if (k >= 20) end_sim(1'h1);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
        int k;
        for (k = 0; k < 200; k++)
        begin
            apb(1'h0, a, 32'h0);
            if ((rd & m) === v) break;
        end
        if (k >= 200) end_sim(1'h1);
    endtask
    // edges for which the refresh line keeps one level
    task automatic run(input logic v, output int n);
        for (n = 0; refr === v && n < 400; n++)
            @(posedge pclk);
    endtask
    // one management access, done flag cleared behind it
    task automatic mg(input logic w, input logic [4:0] dev, input logic [5:0] rg, input logic [15:0] d);
        apb(1'h1, 8'h14, {16'h0, d});
        apb(1'h1, 8'h10, {15'h0, w, 3'h0, dev, 2'h0, rg});
        poll(8'h08, 32'h4, 32'h4);
        apb(1'h1, 8'h08, 32'h4);
        poll(8'h04, 32'h8, 32'h0);
        apb(1'h0, 8'h18, 32'h0);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sleep, ce, padv} <= {45'h0, 1'h1, 16'h0002};
        {rdv, tv, lk, rnib, tn} <= 11'h100;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ROWS[r])
        begin
            mg(1'h0, ROWS[r][26:22], ROWS[r][21:16], 16'h0);
            `CK("reg", ROWS[r][15:0], rd[15:0])
        end
        mg(1'h1, 5'h07, 6'h3C, 16'h0002);
        mg(1'h1, 5'h00, 6'h00, 16'h0200);
        `CK("eee", 5'h11, {eee_en, n_an[3:0]})
        mg(1'h1, 5'h00, 6'h13, 16'h0010);
        `CK("swing", 1'h0, swing)
        mg(1'h1, 5'h1C, 6'h04, 16'h0000);
        `CK("swing", 1'h1, swing)
        apb(1'h1, 8'h00, 32'h1);
        poll(8'h04, 32'h1, 32'h1);
        mg(1'h0, 5'h01, 6'h01, 16'h0);
        `CK("tx", 8'h47, {mii.txen, mii.txer, mii.txd, tx_lpi, rd[9]})
        run(1'h1, k);
        run(1'h0, k);
        run(1'h1, k);
        `CK("burst", 50, k)
        run(1'h0, k);
        `CK("quiet", 300, k)
        sleep <= 1'h1;
        poll(8'h04, 32'h6, 32'h6);
        `CK("rx", 8'h47, {mii.rxdv, mii.rxer, mii.rxd, tx_lpi, rx_lpi})
        apb(1'h1, 8'h0C, 32'h1);
        apb(1'h0, 8'h08, 32'h0);
        `CK("irq", 2'h3, {irq, rd[0]})
        apb(1'h1, 8'h08, 32'h1);
        apb(1'h0, 8'h08, 32'h0);
        `CK("clr", 2'h0, {irq, rd[0]})
        mg(1'h1, 5'h03, 6'h00, 16'h0000);
        poll(8'h04, 32'h6, 32'h2);
        mg(1'h1, 5'h03, 6'h00, 16'h0400);
        poll(8'h04, 32'h6, 32'h6);
        sleep <= 1'h0;
        poll(8'h04, 32'h6, 32'h0);
        `CK("rxexit", 3'h1, {mii.rxer, rx_lpi, tx_lpi})
        apb(1'h1, 8'h00, 32'h0);
        poll(8'h04, 32'h1, 32'h0);
        apb(1'h1, 8'h0C, 32'h0);
        apb(1'h0, 8'h40, 32'h0);
        `CK("exit", 2'h1, {tx_lpi, err})
        {rdv, tv, rnib, tn} <= 10'h3A6;
        repeat (24) @(posedge pclk);
        k = 0;
        repeat (32)
        begin
            @(posedge pclk);
            k += rxv + 16 * txr;
        end
        `CK("rxdata", 9'h1AA, {mii.rxdv, mii.rxd, rxn})
        `CK("txdata", 13'h1644, {ltxen, ltxn, k[7:0]})
        {tv, lk} <= 2'h0;
        k = 0;
        repeat (250)
        begin
            @(posedge pclk);
            k += nlp;
        end
        `CK("nlp", 2, k)
        end_sim(1'h0);
    end
endmodule
`default_nettype wire
